/* File: rlsc_asserts.sv */
`timescale 1ns/1ps
module rlsc_asserts
    import rlsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Watched ports
    input wire rlsc_pkg::rlsc_port_ev_t [1:0] port_ev,
    input wire rlsc_pkg::rlsc_frame_t [1:0] port_frame,
    input wire logic [1:0] reply_permit,
    input wire logic running,
    input wire logic alarm_reset,
    input wire logic port1_comm_alarm,
    input wire logic param_wr_valid,
    input wire logic nvm_wr,
    input wire logic temp_wr,
    input wire logic save_all_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    loader_frame_a: assert property (port_frame[0].loader |-> port_frame[0].parity_en
        && !port_frame[0].parity_odd && !port_frame[0].two_stop) else $error("loader framing");
    write_route_a: assert property (param_wr_valid |=> nvm_wr ^ temp_wr)
        else $error("write not routed");
    route_idle_a: assert property (!param_wr_valid |=> !nvm_wr && !temp_wr)
        else $error("spurious write");
    save_pulse_a: assert property (save_all_req |=> !save_all_req)
        else $error("save request too long");
    reply_gate_a: assert property (port_ev[0].request |=> !reply_permit[0])
        else $error("reply permitted early");
    reply_drop_a: assert property (port_ev[0].tx_start |=> !reply_permit[0])
        else $error("permit kept after reply");
    // The output lags the latch by one cycle, so a reset shows two cycles later
    alarm_hold_a: assert property (port1_comm_alarm && !alarm_reset && !$past(alarm_reset)
        |=> port1_comm_alarm)
        else $error("alarm dropped");
    stopped_trip_a: assert property (!running |=> !$rose(port1_comm_alarm))
        else $error("trip while stopped");
endmodule

/* File: rlsc_host.sv */
`timescale 1ns/1ps
module rlsc_host (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control from the bench
    input wire logic ask,
    input wire logic keepalive,
    // Link
    input wire logic permit,
    output rlsc_pkg::rlsc_port_ev_t ev
);
    int gap;
    int held;
    logic pend;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ev <= '0;
            gap <= 0;
            held <= 0;
            pend <= 1'b0;
        end else begin
            ev <= '0;
            gap <= (gap == 199) ? 0 : gap + 1;
            ev.frame_valid <= keepalive && gap == 199;
            if (ask) begin
                ev.request <= 1'b1;
                pend <= 1'b1;
                held <= 0;
            end else if (pend && permit) begin
                // No fixed turnaround assumed: waits for the permit, then answers slowly
                held <= held + 1;
                ev.tx_start <= held == 3;
                pend <= held != 3;
            end
        end
    end
endmodule

/* File: rlsc_pkg.sv */
package rlsc_pkg;

    // Clock and time base
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_TENTH = 10;
    localparam int TENTHS_PER_SEC = 10;

    // Register map (byte addresses)
    localparam logic [7:0] OFS_PORT1_CFG = 8'h00;
    localparam logic [7:0] OFS_PORT2_CFG = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_FREQ = 8'h0C;
    localparam logic [7:0] OFS_SPEED_RUN = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Limits of the settings
    localparam logic [5:0] TIMEOUT_MAX = 6'h3C;
    localparam logic [6:0] REPLY_MAX = 7'h64;
    localparam logic [9:0] ERR_TIMER_MAX = 10'h258;

    // Codes
    localparam logic [1:0] PAR_NONE2 = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic STOP_TWO = 1'h0;
    localparam logic [1:0] PROTO_MODBUS = 2'h0;
    localparam logic [1:0] PROTO_LOADER = 2'h1;
    localparam logic [1:0] ACT_TRIP = 2'h0;
    localparam logic [1:0] ACT_RUN_TIMER = 2'h1;
    localparam logic [1:0] ACT_RETRY = 2'h2;
    localparam logic [1:0] STORE_NVM = 2'h0;
    localparam logic [1:0] STORE_TEMP = 2'h1;
    localparam logic [1:0] STORE_SAVE_ALL = 2'h2;

    // Reset values
    localparam logic [31:0] PORT_CFG_RST = 32'h0000_0001;
    localparam logic [15:0] RUN_BITS_MASK_DEF = 16'h0003;

    // Per-port setting word, bit 0 upward: parity, stop, protocol, action,
    // timeout seconds, reply delay (10 ms), error timer (100 ms)
    typedef struct packed {
        logic [1:0] pad;
        logic [9:0] err_timer;
        logic [6:0] reply_delay;
        logic [5:0] timeout_seconds;
        logic [1:0] error_action;
        logic [1:0] protocol_code;
        logic stop_bits_code;
        logic [1:0] parity_code;
    } rlsc_port_cfg_t;

    // Character framing handed to the UART of a port
    typedef struct packed {
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic loader;
    } rlsc_frame_t;

    // Events from the UART of a port
    typedef struct packed {
        logic frame_valid;
        logic request;
        logic rx_error;
        logic tx_start;
    } rlsc_port_ev_t;

    typedef enum logic [1:0] {
        RLSC_ERR_IDLE = 2'b00,
        RLSC_ERR_RUN_TIMER = 2'b01,
        RLSC_ERR_RETRY = 2'b10
    } rlsc_err_state_t;

    typedef enum logic {
        RLSC_STORE_IDLE = 1'b0,
        RLSC_STORE_SAVING = 1'b1
    } rlsc_store_state_t;

endpackage

/* File: rlsc_top.sv */
// How it works
// - Parity code: 0 none, 1 even, 2 odd, 3 none.
// - Modbus ignores stop setting: parity code 0 gives two stops, others one.
// - Loader protocol always frames with even parity.
// - Stop code: 0 gives two stop bits, 1 gives one.
// - Loader protocol always uses exactly one stop bit.
// - Timeout setting zero disables disconnection detection.
// - Timeout 1..60: no access for that many seconds raises a port error.
// - Reply may start only after the programmed interval following a request.
// - Protocol code: 0 Modbus, 1 loader, 2 unused.
// - Any port, fieldbus or option communication alarm triggers command clearing.
// - Clear mode 0 keeps all command data.
// - Clear mode 1 clears frequency and speed reference words.
// - Clear mode 2 clears only run bits of the run word.
// - Clear mode 3 does both clears.
// - Link parameter writes go to non-volatile (0) or temporary (1) memory.
// - Store target 2 saves all temporary data, then returns to 1.
// - Loader link mode 1 frequency, 2 run, 3 both from loader.
// - Loader link mode 0 takes commands from normal sources.
// - Loader link mode is volatile and zero after power-up.
// - Error action: 0 trip, 1 run timer then trip, 2 retry then trip, 3 run.
// - Port errors are judged only while running from that port.
`timescale 1ns/1ps
module rlsc_top
    import rlsc_pkg::*;
#(
    parameter int TICK_CYCLES_P = rlsc_pkg::TICK_CYCLES,
    parameter logic [15:0] RUN_BITS_MASK = rlsc_pkg::RUN_BITS_MASK_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial ports
    input wire rlsc_pkg::rlsc_port_ev_t [1:0] port_ev,
    output rlsc_pkg::rlsc_frame_t [1:0] port_frame,
    output logic [1:0] reply_permit,
    // Drive state and other alarm sources
    input wire logic running,
    input wire logic fieldbus_alarm,
    input wire logic option_alarm,
    input wire logic alarm_reset,
    output logic port1_comm_alarm,
    output logic port2_comm_alarm,
    // Command words
    output logic [15:0] freq_reference_word,
    output logic [15:0] freq_reference_alt_word,
    output logic [15:0] speed_reference_word,
    output logic [15:0] run_command_word,
    output logic freq_from_loader,
    output logic run_from_loader,
    // Parameter storage
    input wire logic param_wr_valid,
    input wire logic save_all_done,
    output logic nvm_wr,
    output logic temp_wr,
    output logic save_all_req
);
    import rlsc_pkg::*;

    rlsc_port_cfg_t [1:0] cfg;
    logic [1:0] command_clear_mode;
    logic [1:0] parameter_store_target;
    logic [1:0] fieldbus_command_source;
    logic [1:0] loader_link_mode;
    logic [3:0] link_command_source;
    logic [31:0] next_rdata;
    logic [17:0] div_cnt;
    logic [3:0] tenth_cnt;
    logic [3:0] sec_cnt;
    logic tick10ms;
    logic tick100ms;
    logic tick1s;
    logic [6:0] idle_sec [2];
    logic [1:0] timed_out;
    logic [1:0] timed_out_q;
    logic [7:0] reply_cnt [2];
    logic [1:0] reply_pending;
    logic [10:0] err_cnt [2];
    rlsc_err_state_t err_state [2];
    logic [1:0] judging;
    logic [1:0] port_err;
    logic [1:0] trip;
    logic [1:0] alarm;
    logic any_alarm_event;
    rlsc_store_state_t store_state;

    function automatic logic wr_hit(input logic [7:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction

    // Clamp a stored setting to its documented maximum
    function automatic rlsc_port_cfg_t clamp_cfg(input logic [31:0] w);
        rlsc_port_cfg_t c;
        c = rlsc_port_cfg_t'(w);
        c.pad = 2'h0;
        if (c.timeout_seconds > TIMEOUT_MAX) begin
            c.timeout_seconds = TIMEOUT_MAX;
        end
        if (c.reply_delay > REPLY_MAX) begin
            c.reply_delay = REPLY_MAX;
        end
        if (c.err_timer > ERR_TIMER_MAX) begin
            c.err_timer = ERR_TIMER_MAX;
        end
        return c;
    endfunction

    // Framing decode for one port
    function automatic rlsc_frame_t frame_of(input rlsc_port_cfg_t c);
        rlsc_frame_t f;
        f.loader = (c.protocol_code == PROTO_LOADER);
        f.parity_en = (c.parity_code == PAR_EVEN) || (c.parity_code == PAR_ODD);
        f.parity_odd = (c.parity_code == PAR_ODD);
        f.two_stop = (c.stop_bits_code == STOP_TWO);
        if (c.protocol_code == PROTO_MODBUS) begin
            f.two_stop = (c.parity_code == PAR_NONE2);
        end else if (f.loader) begin
            f.parity_en = 1'b1;
            f.parity_odd = 1'b0;
            f.two_stop = 1'b0;
        end
        return f;
    endfunction

    // Settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg[0] <= rlsc_port_cfg_t'(PORT_CFG_RST);
            cfg[1] <= rlsc_port_cfg_t'(PORT_CFG_RST);
        end else begin
            if (wr_hit(OFS_PORT1_CFG)) begin
                cfg[0] <= clamp_cfg(reg_wdata);
            end
            if (wr_hit(OFS_PORT2_CFG)) begin
                cfg[1] <= clamp_cfg(reg_wdata);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            command_clear_mode <= 2'h0;
            fieldbus_command_source <= 2'h0;
            loader_link_mode <= 2'h0;
            link_command_source <= 4'h0;
        end else if (wr_hit(OFS_CTRL)) begin
            command_clear_mode <= reg_wdata[1:0];
            fieldbus_command_source <= reg_wdata[5:4];
            loader_link_mode <= reg_wdata[7:6];
            link_command_source <= reg_wdata[11:8];
        end
    end

    // Which source feeds the drive; mode 0 leaves the normal selection alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_from_loader <= 1'b0;
            run_from_loader <= 1'b0;
        end else begin
            freq_from_loader <= loader_link_mode[0];
            run_from_loader <= loader_link_mode[1];
        end
    end

    // Parameter storage routing and save-all sequence
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            parameter_store_target <= STORE_NVM;
            store_state <= RLSC_STORE_IDLE;
            save_all_req <= 1'b0;
        end else begin
            unique case (store_state)
                RLSC_STORE_IDLE: begin
                    if (wr_hit(OFS_CTRL) && reg_wdata[3:2] == STORE_SAVE_ALL) begin
                        parameter_store_target <= STORE_SAVE_ALL;
                        store_state <= RLSC_STORE_SAVING;
                        save_all_req <= 1'b1;
                    end else if (wr_hit(OFS_CTRL) && reg_wdata[3:2] != 2'h3) begin
                        parameter_store_target <= reg_wdata[3:2];
                    end
                end
                RLSC_STORE_SAVING: begin
                    save_all_req <= 1'b0;
                    if (save_all_done) begin
                        parameter_store_target <= STORE_TEMP;
                        store_state <= RLSC_STORE_IDLE;
                    end
                end
            endcase
        end
    end

    // While a save-all runs, new writes still land in temporary memory
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nvm_wr <= 1'b0;
            temp_wr <= 1'b0;
        end else begin
            nvm_wr <= param_wr_valid && (parameter_store_target == STORE_NVM);
            temp_wr <= param_wr_valid && (parameter_store_target != STORE_NVM);
        end
    end

    // Time base: 10 ms, 100 ms and 1 s enables
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 18'h0;
            tenth_cnt <= 4'h0;
            sec_cnt <= 4'h0;
            tick10ms <= 1'b0;
            tick100ms <= 1'b0;
            tick1s <= 1'b0;
        end else begin
            tick10ms <= 1'b0;
            tick100ms <= 1'b0;
            tick1s <= 1'b0;
            if (div_cnt == 18'(TICK_CYCLES_P - 1)) begin
                div_cnt <= 18'h0;
                tick10ms <= 1'b1;
                if (tenth_cnt == 4'(TICKS_PER_TENTH - 1)) begin
                    tenth_cnt <= 4'h0;
                    tick100ms <= 1'b1;
                    if (sec_cnt == 4'(TENTHS_PER_SEC - 1)) begin
                        sec_cnt <= 4'h0;
                        tick1s <= 1'b1;
                    end else begin
                        sec_cnt <= sec_cnt + 4'h1;
                    end
                end else begin
                    tenth_cnt <= tenth_cnt + 4'h1;
                end
            end else begin
                div_cnt <= div_cnt + 18'h1;
            end
        end
    end

    // Framing follows settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_frame <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                port_frame[i] <= frame_of(cfg[i]);
            end
        end
    end

    // No-access supervision; one extra second absorbs the free-running tick phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_sec <= '{7'h0, 7'h0};
            timed_out <= 2'b00;
            timed_out_q <= 2'b00;
        end else begin
            timed_out_q <= timed_out;
            for (int i = 0; i < 2; i++) begin
                if (port_ev[i].frame_valid || cfg[i].timeout_seconds == 6'h0) begin
                    idle_sec[i] <= 7'h0;
                    timed_out[i] <= 1'b0;
                end else if (tick1s && idle_sec[i] != 7'h7F) begin
                    idle_sec[i] <= idle_sec[i] + 7'h1;
                end
                if (cfg[i].timeout_seconds != 6'h0 &&
                    idle_sec[i] > {1'b0, cfg[i].timeout_seconds}) begin
                    timed_out[i] <= 1'b1;
                end
            end
        end
    end

    // Reply gate; the host still sees extra processing time on top
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reply_cnt <= '{8'h0, 8'h0};
            reply_pending <= 2'b00;
            reply_permit <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (port_ev[i].request) begin
                    reply_cnt[i] <= {1'b0, cfg[i].reply_delay} +
                        {7'h0, cfg[i].reply_delay != 7'h0};
                    reply_pending[i] <= 1'b1;
                    reply_permit[i] <= 1'b0;
                end else if (port_ev[i].tx_start) begin
                    reply_pending[i] <= 1'b0;
                    reply_permit[i] <= 1'b0;
                end else if (reply_pending[i]) begin
                    if (reply_cnt[i] == 8'h0) begin
                        reply_permit[i] <= 1'b1;
                    end else if (tick10ms) begin
                        reply_cnt[i] <= reply_cnt[i] - 8'h1;
                    end
                end
            end
        end
    end

    // Port error detection, gated by run state and command source
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            judging[i] = running && (link_command_source[2*i] || link_command_source[2*i+1]);
            port_err[i] = judging[i] && (port_ev[i].rx_error || (timed_out[i] && !timed_out_q[i]));
            trip[i] = 1'b0;
            unique case (err_state[i])
                RLSC_ERR_IDLE: trip[i] = port_err[i] && cfg[i].error_action == ACT_TRIP;
                RLSC_ERR_RUN_TIMER,
                RLSC_ERR_RETRY: trip[i] = judging[i] && err_cnt[i] == 11'h0;
                default: trip[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_state <= '{RLSC_ERR_IDLE, RLSC_ERR_IDLE};
            err_cnt <= '{11'h0, 11'h0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                unique case (err_state[i])
                    RLSC_ERR_IDLE: begin
                        err_cnt[i] <= {1'b0, cfg[i].err_timer} +
                            {10'h0, cfg[i].err_timer != 10'h0};
                        if (port_err[i] && cfg[i].error_action == ACT_RUN_TIMER) begin
                            err_state[i] <= RLSC_ERR_RUN_TIMER;
                        end else if (port_err[i] && cfg[i].error_action == ACT_RETRY) begin
                            err_state[i] <= RLSC_ERR_RETRY;
                        end
                    end
                    RLSC_ERR_RUN_TIMER,
                    RLSC_ERR_RETRY: begin
                        if (!judging[i] || trip[i]) begin
                            err_state[i] <= RLSC_ERR_IDLE;
                        end else if (err_state[i] == RLSC_ERR_RETRY && port_ev[i].frame_valid) begin
                            err_state[i] <= RLSC_ERR_IDLE;
                        end else if (tick100ms) begin
                            err_cnt[i] <= err_cnt[i] - 11'h1;
                        end
                    end
                    default: err_state[i] <= RLSC_ERR_IDLE;
                endcase
            end
        end
    end

    // Alarm latches; a new trip beats a reset in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (trip[i]) begin
                    alarm[i] <= 1'b1;
                end else if (alarm_reset) begin
                    alarm[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port1_comm_alarm <= 1'b0;
            port2_comm_alarm <= 1'b0;
        end else begin
            port1_comm_alarm <= alarm[0] || trip[0];
            port2_comm_alarm <= alarm[1] || trip[1];
        end
    end

    assign any_alarm_event = (trip != 2'b00) || fieldbus_alarm || option_alarm;

    // Command words; an alarm clear wins over a same-cycle write for safety
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_reference_word <= 16'h0;
            freq_reference_alt_word <= 16'h0;
            speed_reference_word <= 16'h0;
            run_command_word <= 16'h0;
        end else begin
            if (any_alarm_event && command_clear_mode[0]) begin
                freq_reference_word <= 16'h0;
                freq_reference_alt_word <= 16'h0;
                speed_reference_word <= 16'h0;
            end else if (wr_hit(OFS_FREQ)) begin
                freq_reference_word <= reg_wdata[15:0];
                freq_reference_alt_word <= reg_wdata[31:16];
            end else if (wr_hit(OFS_SPEED_RUN)) begin
                speed_reference_word <= reg_wdata[15:0];
            end
            if (any_alarm_event && command_clear_mode[1]) begin
                if (wr_hit(OFS_SPEED_RUN)) begin
                    run_command_word <= reg_wdata[31:16] & ~RUN_BITS_MASK;
                end else begin
                    run_command_word <= run_command_word & ~RUN_BITS_MASK;
                end
            end else if (wr_hit(OFS_SPEED_RUN)) begin
                run_command_word <= reg_wdata[31:16];
            end
        end
    end

    // Read path
    always_comb begin
        next_rdata = 32'h0;
        unique case (reg_addr)
            OFS_PORT1_CFG: next_rdata = 32'(cfg[0]);
            OFS_PORT2_CFG: next_rdata = 32'(cfg[1]);
            OFS_CTRL: next_rdata = {20'h0, link_command_source, loader_link_mode,
                fieldbus_command_source, parameter_store_target, command_clear_mode};
            OFS_FREQ: next_rdata = {freq_reference_alt_word, freq_reference_word};
            OFS_SPEED_RUN: next_rdata = {run_command_word, speed_reference_word};
            OFS_STATUS: next_rdata = {23'h0, store_state == RLSC_STORE_SAVING, reply_permit,
                judging, timed_out, alarm};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

/* File: rlsc_top_tb.sv */
`timescale 1ns/1ps
module rlsc_top_tb;
    import rlsc_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, running, fieldbus_alarm, option_alarm, alarm_reset;
    logic param_wr_valid, save_all_done, nvm_wr, temp_wr, save_all_req, p1a, p2a, ffl, rfl;
    logic ask, keepalive;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] fw, faw, sw, rw;
    logic [1:0] reply_permit;
    rlsc_port_ev_t host_ev;
    rlsc_port_ev_t [1:0] port_ev;
    rlsc_frame_t [1:0] port_frame;
    int n_errors = 0;
    int compares = 0;
    assign port_ev = {4'h0, host_ev};
    rlsc_top #(.TICK_CYCLES_P(4)) rlsc_top_inst (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port_ev(port_ev), .port_frame(port_frame),
        .reply_permit(reply_permit), .running(running), .fieldbus_alarm(fieldbus_alarm),
        .option_alarm(option_alarm), .alarm_reset(alarm_reset), .port1_comm_alarm(p1a),
        .port2_comm_alarm(p2a), .freq_reference_word(fw), .freq_reference_alt_word(faw),
        .speed_reference_word(sw), .run_command_word(rw), .freq_from_loader(ffl),
        .run_from_loader(rfl), .param_wr_valid(param_wr_valid),
        .save_all_done(save_all_done), .nvm_wr(nvm_wr), .temp_wr(temp_wr),
        .save_all_req(save_all_req));
    rlsc_host rlsc_host_inst (.clk(clk), .arst_n(arst_n), .ask(ask), .keepalive(keepalive),
        .permit(reply_permit[0]), .ev(host_ev));
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic end_sim();
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_reset();
        tick(1);
        chk("frame", 32'(port_frame[0]), 32'h8);
        chk("loader", {rfl, ffl}, 0);
        rd(OFS_PORT1_CFG);
        chk("cfg", d, PORT_CFG_RST);
        rd(8'h20);
        chk("unmapped", d, 0);
    endtask
    task automatic t_frame();
        int p, s, q;
        for (int i = 0; i < 24; i++) begin
            {p, s, q} = {i / 8, (i / 4) % 2, i % 4};
            wr(OFS_PORT1_CFG, 32'(p * 8 + s * 4 + q));
            tick(1);
            chk("frame", 32'(port_frame[0]), (p == 1) ? 32'h9 :
                {q == 1 || q == 2, q == 2, (p == 0) ? q == 0 : s == 0, 1'b0});
        end
        chk("frame2", 32'(port_frame[1]), 32'h8);
    endtask
    task automatic t_reply();
        int n;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_PORT1_CFG, 32'h1 | (32'(k) << 13));
            ask <= 1'b1;
            @(posedge clk);
            ask <= 1'b0;
            @(posedge clk);
            n = 0;
            do tick(1); while (reply_permit[0] !== 1'b1 && ++n < 40);
            chk("delay", (k == 0) ? n == 0 : n >= 4 * k + 1 && n <= 4 * k + 4, 1);
            tick(6);
            chk("permit", reply_permit[0], 0);
        end
    endtask
    task automatic t_clear();
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 32'(m));
            wr(OFS_FREQ, 32'h1111_2222);
            wr(OFS_SPEED_RUN, 32'hFFFF_3333);
            if (m < 2) fieldbus_alarm <= 1'b1;
            else option_alarm <= 1'b1;
            @(posedge clk);
            {fieldbus_alarm, option_alarm} <= 2'h0;
            tick(1);
            chk("freq", {faw, fw}, m[0] ? 0 : 32'h1111_2222);
            chk("speed", {rw, sw}, {m[1] ? 16'hFFFC : 16'hFFFF, m[0] ? 16'h0 : 16'h3333});
        end
    endtask
    task automatic t_store();
        for (int t = 0; t < 2; t++) begin
            wr(OFS_CTRL, 32'(t) << 2);
            param_wr_valid <= 1'b1;
            @(posedge clk);
            param_wr_valid <= 1'b0;
            #1 chk("route", {nvm_wr, temp_wr}, t ? 2'h1 : 2'h2);
        end
        wr(OFS_CTRL, 32'h8);
        #1 chk("save", save_all_req, 1);
        rd(OFS_CTRL);
        chk("saving", d[3:2], 2);
        @(posedge clk);
        save_all_done <= 1'b1;
        @(posedge clk);
        save_all_done <= 1'b0;
        rd(OFS_CTRL);
        chk("restored", d[3:2], 1);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 32'(m) << 6);
            tick(1);
            chk("loader", {rfl, ffl}, m);
        end
    endtask
    task automatic t_timeout();
        int n;
        wr(OFS_PORT1_CFG, 32'h81);
        wr(OFS_CTRL, 32'h100);
        {keepalive, running} <= 2'h3;
        tick(1500);
        chk("alive", p1a, 0);
        @(posedge clk);
        keepalive <= 1'b0;
        n = 0;
        do tick(1); while (p1a !== 1'b1 && ++n < 1200);
        chk("trip", n >= 200 && n <= 850, 1);
        chk("port2", p2a, 0);
        @(posedge clk);
        {running, alarm_reset} <= 2'h1;
        @(posedge clk);
        alarm_reset <= 1'b0;
        wr(OFS_PORT1_CFG, 32'h1);
        running <= 1'b1;
        tick(1000);
        chk("no detect", p1a, 0);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {arst_n, reg_addr, reg_wdata, reg_wr, reg_rd, running, fieldbus_alarm} = '0;
        {option_alarm, alarm_reset, param_wr_valid, save_all_done, ask, keepalive} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_frame();
        t_reply();
        t_clear();
        t_store();
        t_timeout();
        end_sim();
    end
    initial begin
        // Whole run needs well under 6000 cycles
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
bind rlsc_top rlsc_asserts rlsc_asserts_inst (.clk(clk), .arst_n(arst_n), .port_ev(port_ev),
    .port_frame(port_frame), .reply_permit(reply_permit), .running(running),
    .alarm_reset(alarm_reset), .port1_comm_alarm(port1_comm_alarm),
    .param_wr_valid(param_wr_valid), .nvm_wr(nvm_wr), .temp_wr(temp_wr),
    .save_all_req(save_all_req));
